// >>> core/rss_consts.vh
// Constants for the reset source sequencer: flag positions, vectors, timing.
// Assumes a 125 MHz system clock; included by bare name.
`ifndef RSS_CONSTS_VH
`define RSS_CONSTS_VH
// ****************************************
// Cause flag positions in the reset control word
// ****************************************
`define RSS_BIT_TRAP        9
`define RSS_BIT_ILLOP       8
`define RSS_BIT_EXTERNAL_RESET_FLAG        7
`define RSS_BIT_SWR         6
`define RSS_BIT_WATCHDOG_TIMEOUT_FLAG        5
`define RSS_BIT_IDLE        4
`define RSS_BIT_SLEEP       3
`define RSS_BIT_POR         2
`define RSS_BIT_BOR         1
`define RSS_FLAGS_W         10
`define RSS_FLAGS_RST       10'h006
// ****************************************
// Restart vectors and oscillator control
// ****************************************
`define RSS_VEC_RESET       24'h000000
`define RSS_VEC_CLKFAIL     24'h000004
`define RSS_PC_STEP         24'h000002
`define RSS_LOCK_BIT        5
`define RSS_FOS_W           3
`define RSS_FPR_W           5
`define RSS_FOS_FRC         3'h1
// ****************************************
// Timing
// ****************************************
`define RSS_CLK_MHZ         125
`define RSS_MON_DELAY_US    100
// Monitor delay is 100 us at 125 MHz; counts sized to the 24-bit counters
`define RSS_MON_DELAY_CYC   24'h0030D4
`define RSS_POR_CYC         24'h001000
`define RSS_POWER_UP_TIMER_CYC        24'h002000
`define RSS_OST_CYC         24'h000400
`define RSS_CNT_W           24
`endif

// >>> core/rss_reset_source_sequencer.v
// Reset sequencing, restart vector choice and reset cause flags.
// Assumes supply, pin, watchdog, trap and clock events arrive as ports;
// pin, comparator and oscillator-running inputs are asynchronous, the rest share i_clk.
`timescale 1ns/1ns
`include "rss_consts.vh"
module rss_reset_source_sequencer #(
  parameter [23:0] POR_CYC  = `RSS_POR_CYC,        // Power-on timeout cycles
  parameter [23:0] POWER_UP_TIMER_CYC = `RSS_POWER_UP_TIMER_CYC,       // Power-up timeout cycles
  parameter [23:0] MON_CYC  = `RSS_MON_DELAY_CYC   // Clock monitor delay cycles
) (
  input  wire        i_clk,              // System clock
  input  wire        i_sys_rst,          // Async reset, high: power-on
  input  wire        i_master_clear_n,   // Master clear pin, low active
  input  wire [1:0]  i_bor_level,        // Trip threshold select, 0..2
  input  wire [2:0]  i_supply_below,     // Comparator per threshold, async
  input  wire        i_bor_enable,       // Brown-out detector enable
  input  wire        i_monitor_enable,   // Clock fail monitor enable
  input  wire        i_power_up_timer_enable,      // Power-up timer enable
  input  wire        i_crystal_mode,     // Oscillator mode uses a crystal
  input  wire        i_pll_used,         // PLL in use
  input  wire [2:0]  i_osc_source_select,// Config oscillator source
  input  wire [4:0]  i_primary_osc_mode, // Config primary mode
  input  wire        i_osc_running,      // Oscillator running, async
  input  wire [7:0]  i_osc_control_reg,  // Oscillator control, lock at bit 5
  input  wire        i_sleep_mode,       // Device in sleep
  input  wire        i_idle_mode,        // Device in idle
  input  wire        i_sw_reset,         // Software reset pulse
  input  wire        i_wdt_timeout,      // Watchdog timeout pulse
  input  wire        i_trap_reset,       // Trap reset pulse
  input  wire        i_illegal_op,       // Illegal operation pulse
  input  wire        i_wake_irq,         // Interrupt wake-up pulse
  input  wire [23:0] i_irq_vector,       // Vector of waking interrupt
  input  wire [23:0] i_pc,               // Current program counter
  input  wire        i_flags_we,         // Software write of flags
  input  wire [9:0]  i_flags_wdata,      // Software write data
  output reg         o_core_reset,       // Internal reset to whole device
  output reg         o_clk_hold,         // System clock held
  output reg         o_cpu_freeze,       // Core frozen at reset vector
  output reg         o_clk_fail_trap,    // Clock failure trap pulse
  output reg         o_use_fast_rc,      // Switch to internal fast RC
  output reg  [2:0]  o_clk_source,       // Chosen clock source
  output reg  [4:0]  o_clk_mode,         // Chosen primary mode
  output reg         o_pc_load,          // Load restart PC pulse
  output reg  [23:0] o_pc_value,         // Restart PC
  output reg  [9:0]  o_reset_control_reg // Cause flags, readable
);
  // ****************************************
  // Sequencer states
  // ****************************************
  localparam [1:0] ST_HOLD = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_RUN  = 2'h2;

  reg  [1:0]  state;
  reg  [23:0] por_cnt;
  reg  [23:0] power_up_timer_cnt;
  reg  [23:0] ost_cnt;
  reg  [23:0] mon_cnt;
  reg  [2:0]  master_clear_pin_s;
  reg  [2:0]  run_s;
  reg         master_clear_pin_n;
  reg         osc_ok;
  reg         master_clear_pin_n_d;
  reg         bor_evt;
  wire [2:0]  sup_q;
  wire        sup_sel;
  wire        lock;
  wire        timers_done;
  wire        clk_ready;
  wire        master_clear_pin_evt;
  wire [23:0] mon_need;

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Three stages; level taken only once stage two and three agree
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      master_clear_pin_s <= 3'h7;
      run_s  <= 3'h0;
      master_clear_pin_n <= 1'b1;
      osc_ok <= 1'b0;
    end else begin
      master_clear_pin_s <= {master_clear_pin_s[1:0], i_master_clear_n};
      run_s  <= {run_s[1:0], i_osc_running};
      if (master_clear_pin_s[1] == master_clear_pin_s[2])
        master_clear_pin_n <= master_clear_pin_s[2];
      if (run_s[1] == run_s[2])
        osc_ok <= run_s[2];
    end
  end

  // Per-threshold comparator synchronisers, one per trip point
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sup
      reg [2:0] s;
      reg       q;
      always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          s <= 3'h0;
          q <= 1'b0;
        end else begin
          s <= {s[1:0], i_supply_below[g]};
          if (s[1] == s[2])
            q <= s[2];
        end
      end
      assign sup_q[g] = q;
    end
  endgenerate

  // ****************************************
  // Derived conditions
  // ****************************************
  // Level 3 is not a legal trip point; it falls back to the lowest
  assign sup_sel = (i_bor_level == 2'h1) ? sup_q[1] :
                   (i_bor_level == 2'h2) ? sup_q[2] : sup_q[0];
  assign lock        = i_osc_control_reg[`RSS_LOCK_BIT];
  // Zero power-up delay with crystal replaces it by monitor delay
  assign mon_need    = (!i_power_up_timer_enable && i_crystal_mode) ? MON_CYC : 24'h000000;
  assign timers_done = (por_cnt == 24'h000000) && (power_up_timer_cnt == 24'h000000)
                       && (mon_cnt >= mon_need);
  assign clk_ready   = osc_ok && (!i_crystal_mode || ost_cnt == 24'h000000)
                       && (!i_pll_used || lock);
  assign master_clear_pin_evt    = master_clear_pin_n_d && !master_clear_pin_n;

  // ****************************************
  // Brown-out detection, awake in sleep and idle as well
  // ****************************************
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bor_evt  <= 1'b0;
      master_clear_pin_n_d <= 1'b1;
    end else begin
      master_clear_pin_n_d <= master_clear_pin_n;
      // No gating on sleep or idle: the detector keeps watching
      bor_evt  <= i_bor_enable && sup_sel && state == ST_RUN;
    end
  end

  // ****************************************
  // Reset sequencer
  // ****************************************
  // Power-on and power-up timers count down together; start-up counts once the clock runs, monitor delay counts up after power-on
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state           <= ST_HOLD;
      por_cnt         <= 24'h000000;
      power_up_timer_cnt        <= 24'h000000;
      ost_cnt         <= 24'h000000;
      mon_cnt         <= 24'h000000;
      o_core_reset    <= 1'b1;
      o_clk_hold      <= 1'b1;
      o_cpu_freeze    <= 1'b0;
      o_clk_fail_trap <= 1'b0;
      o_use_fast_rc   <= 1'b0;
      o_clk_source    <= 3'h0;
      o_clk_mode      <= 5'h00;
    end else begin
      o_clk_fail_trap <= 1'b0;
      case (state)
        ST_HOLD: begin
          // Loaded at release so a shortened parameter takes effect
          por_cnt      <= POR_CYC;
          power_up_timer_cnt     <= i_power_up_timer_enable ? POWER_UP_TIMER_CYC : 24'h000000;
          ost_cnt      <= `RSS_OST_CYC;
          mon_cnt      <= 24'h000000;
          o_clk_source <= i_osc_source_select;
          o_clk_mode   <= i_primary_osc_mode;
          o_use_fast_rc <= 1'b0;
          o_core_reset <= 1'b1;
          o_clk_hold   <= 1'b1;
          state        <= ST_WAIT;
        end
        ST_WAIT: begin
          if (por_cnt != 24'h000000)
            por_cnt <= por_cnt - 24'h000001;
          if (power_up_timer_cnt != 24'h000000)
            power_up_timer_cnt <= power_up_timer_cnt - 24'h000001;
          if (osc_ok && ost_cnt != 24'h000000)
            ost_cnt <= ost_cnt - 24'h000001;
          if (por_cnt == 24'h000000 && mon_cnt < mon_need)
            mon_cnt <= mon_cnt + 24'h000001;
          o_clk_hold <= !clk_ready;
          if (timers_done) begin
            if (i_monitor_enable && !clk_ready) begin
              o_clk_fail_trap <= 1'b1;
              o_use_fast_rc   <= 1'b1;
              o_clk_source    <= `RSS_FOS_FRC;
              o_clk_hold      <= 1'b0;
              o_cpu_freeze    <= 1'b0;
              o_core_reset    <= 1'b0;
              state           <= ST_RUN;
            end else begin
              // Reset released; core stays frozen until clk_ready, which still needs the oscillator running, crystal start-up in crystal mode and, if used, PLL lock
              o_core_reset <= 1'b0;
              o_cpu_freeze <= !clk_ready;
              if (clk_ready)
                state <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          o_cpu_freeze <= 1'b0;
          o_clk_hold   <= 1'b0;
          if (bor_evt || !master_clear_pin_n) begin
            // Whole device reset, sequence restarts
            o_core_reset <= 1'b1;
            state        <= ST_HOLD;
          end
        end
        default: state <= ST_HOLD;
      endcase
    end
  end

  // ****************************************
  // Cause flags and restart vector
  // ****************************************
  // Event wins over a software write in the same cycle
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reset_control_reg <= `RSS_FLAGS_RST;
      o_pc_load           <= 1'b0;
      o_pc_value          <= `RSS_VEC_RESET;
    end else begin
      o_pc_load <= 1'b0;
      if (bor_evt) begin
        o_reset_control_reg[`RSS_BIT_BOR] <= 1'b1;
        o_reset_control_reg[`RSS_BIT_POR] <= 1'b0;
        o_pc_load  <= 1'b1;
        o_pc_value <= `RSS_VEC_RESET;
      end else if (master_clear_pin_evt) begin
        o_reset_control_reg[`RSS_BIT_EXTERNAL_RESET_FLAG]  <= 1'b1;
        o_reset_control_reg[`RSS_BIT_WATCHDOG_TIMEOUT_FLAG]  <= 1'b0;
        o_reset_control_reg[`RSS_BIT_IDLE]  <= i_idle_mode && !i_sleep_mode;
        o_reset_control_reg[`RSS_BIT_SLEEP] <= i_sleep_mode;
        if (!i_sleep_mode && !i_idle_mode)
          o_reset_control_reg[`RSS_BIT_SWR] <= 1'b0;
        o_pc_load  <= 1'b1;
        o_pc_value <= `RSS_VEC_RESET;
      end else if (o_clk_fail_trap) begin
        // Flags left unchanged on clock failure
        o_pc_load  <= 1'b1;
        o_pc_value <= `RSS_VEC_CLKFAIL;
      end else if (i_sw_reset) begin
        o_reset_control_reg[`RSS_BIT_SWR]   <= 1'b1;
        o_reset_control_reg[`RSS_BIT_EXTERNAL_RESET_FLAG]  <= 1'b0;
        o_reset_control_reg[`RSS_BIT_WATCHDOG_TIMEOUT_FLAG]  <= 1'b0;
        o_reset_control_reg[`RSS_BIT_IDLE]  <= 1'b0;
        o_reset_control_reg[`RSS_BIT_SLEEP] <= 1'b0;
        o_pc_load  <= 1'b1;
        o_pc_value <= `RSS_VEC_RESET;
      end else if (i_trap_reset || i_illegal_op) begin
        if (i_trap_reset)
          o_reset_control_reg[`RSS_BIT_TRAP] <= 1'b1;
        if (i_illegal_op)
          o_reset_control_reg[`RSS_BIT_ILLOP] <= 1'b1;
        o_pc_load  <= 1'b1;
        o_pc_value <= `RSS_VEC_RESET;
      end else if (i_wdt_timeout && !i_sleep_mode) begin
        o_reset_control_reg[`RSS_BIT_WATCHDOG_TIMEOUT_FLAG]  <= 1'b1;
        o_reset_control_reg[`RSS_BIT_EXTERNAL_RESET_FLAG]  <= 1'b0;
        o_reset_control_reg[`RSS_BIT_SWR]   <= 1'b0;
        o_reset_control_reg[`RSS_BIT_IDLE]  <= 1'b0;
        o_reset_control_reg[`RSS_BIT_SLEEP] <= 1'b0;
        o_pc_load  <= 1'b1;
        o_pc_value <= `RSS_VEC_RESET;
      end else if (i_sleep_mode && (i_wdt_timeout || i_wake_irq)) begin
        o_reset_control_reg[`RSS_BIT_SLEEP] <= 1'b1;
        if (i_wdt_timeout)
          o_reset_control_reg[`RSS_BIT_WATCHDOG_TIMEOUT_FLAG] <= 1'b1;
        o_pc_load  <= 1'b1;
        o_pc_value <= i_wake_irq ? i_irq_vector : i_pc + `RSS_PC_STEP;
      end else if (i_flags_we) begin
        o_reset_control_reg <= i_flags_wdata;
      end
    end
  end

endmodule

// >>> tb/rss_chk.sv
// Checker for the reset source sequencer: restart vectors, flags, timing.
// Bound to the design top module; sees its ports only.
`timescale 1ns/1ns
module rss_chk #(
  parameter [23:0] POR_CYC = 24'h000008 // Power-on timeout cycles
) (
  input wire        i_clk,              // Clock
  input wire        i_sys_rst,          // Power-on reset
  input wire        i_sw_reset,         // Software reset
  input wire        i_trap_reset,       // Trap reset
  input wire        i_illegal_op,       // Illegal operation
  input wire        i_wdt_timeout,      // Watchdog timeout
  input wire        i_sleep_mode,       // Device in sleep
  input wire        i_wake_irq,         // Interrupt wake
  input wire [23:0] i_irq_vector,       // Wake vector
  input wire        i_flags_we,         // Flag write
  input wire [9:0]  i_flags_wdata,      // Flag data
  input wire        i_pll_used,         // PLL in use
  input wire [7:0]  i_osc_control_reg,  // Lock at bit 5
  input wire        o_core_reset,       // Device reset
  input wire        o_clk_hold,         // Clock held
  input wire        o_clk_fail_trap,    // Clock fail trap
  input wire        o_use_fast_rc,      // Fast RC fallback
  input wire        o_pc_load,          // PC load
  input wire [23:0] o_pc_value,         // Restart PC
  input wire [9:0]  o_reset_control_reg // Cause flags
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ****************************************
  // Boot timer; only the first release after power-on is timed
  // ****************************************
  reg [23:0] up_cnt;
  reg        boot;
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      up_cnt <= 24'h000000;
      boot   <= 1'b1;
    end else if (!o_core_reset) begin
      boot <= 1'b0;
    end else if (boot) begin
      up_cnt <= up_cnt + 24'h000001;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  property p_sw;
    i_sw_reset && !o_core_reset && !o_clk_fail_trap
      |=> o_pc_load && o_pc_value == 24'h000000
      && o_reset_control_reg[7:3] == 5'h08;
  endproperty
  a_sw: assert property (p_sw) else $error("sw restart wrong");
  property p_trap;
    i_trap_reset && !i_sw_reset && !o_core_reset && !o_clk_fail_trap
      |=> o_reset_control_reg[9]
      && o_pc_value == 24'h000000;
  endproperty
  a_trap: assert property (p_trap) else $error("trap restart wrong");
  property p_wake;
    // Only a wake from sleep loads the vector; higher causes take the cycle
    i_wake_irq && i_sleep_mode && !i_sw_reset && !i_trap_reset && !i_illegal_op
      && !o_core_reset && !o_clk_fail_trap
      |=> o_pc_value == $past(i_irq_vector) && o_reset_control_reg[3];
  endproperty
  a_wake: assert property (p_wake) else $error("irq wake wrong");
  property p_wr;
    i_flags_we && !(i_sw_reset | i_trap_reset | i_illegal_op | i_wdt_timeout | i_wake_irq)
      && !o_core_reset && !o_clk_fail_trap
      |=> o_reset_control_reg == $past(i_flags_wdata);
  endproperty
  a_wr: assert property (p_wr) else $error("flag write lost");
  property p_cft;
    o_clk_fail_trap |=> !o_clk_fail_trap && o_pc_load && o_pc_value == 24'h000004;
  endproperty
  a_cft: assert property (p_cft) else $error("clock fail vector wrong");
  property p_cfk;
    o_clk_fail_trap |=> $stable(o_reset_control_reg);
  endproperty
  a_cfk: assert property (p_cfk) else $error("clock fail moved flags");
  property p_pll;
    // Lock as seen on the edge that freed the clock; fallback ignores it
    $fell(o_clk_hold) && i_pll_used && !o_use_fast_rc |-> $past(i_osc_control_reg[5]);
  endproperty
  a_pll: assert property (p_pll) else $error("clock freed unlocked");
  property p_por;
    boot && $fell(o_core_reset) |-> up_cnt >= POR_CYC;
  endproperty
  a_por: assert property (p_por) else $error("reset released early");
  c_cf: cover property (o_clk_fail_trap);
  c_wake: cover property (i_wake_irq && i_sleep_mode && !o_core_reset);
  c_sw: cover property (i_sw_reset ##1 o_pc_load);
endmodule
bind rss_reset_source_sequencer rss_chk #(.POR_CYC(POR_CYC)) i_rss_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sw_reset(i_sw_reset),
  .i_trap_reset(i_trap_reset), .i_illegal_op(i_illegal_op),
  .i_wdt_timeout(i_wdt_timeout), .i_sleep_mode(i_sleep_mode),
  .i_wake_irq(i_wake_irq), .i_irq_vector(i_irq_vector),
  .i_flags_we(i_flags_we), .i_flags_wdata(i_flags_wdata), .i_pll_used(i_pll_used),
  .i_osc_control_reg(i_osc_control_reg), .o_core_reset(o_core_reset),
  .o_clk_hold(o_clk_hold), .o_clk_fail_trap(o_clk_fail_trap),
  .o_use_fast_rc(o_use_fast_rc), .o_pc_load(o_pc_load),
  .o_pc_value(o_pc_value), .o_reset_control_reg(o_reset_control_reg));

// >>> tb/tb_top.sv
// Testbench for the reset source sequencer with shortened timeouts.
// Drives every input itself 1 ns after the rising edge of i_clk.
`timescale 1ns/1ns
module tb_top;
  reg         i_clk, i_sys_rst, i_master_clear_n, i_bor_enable, i_monitor_enable;
  reg         i_power_up_timer_enable, i_crystal_mode, i_pll_used, i_osc_running, i_sleep_mode;
  reg         i_idle_mode, i_sw_reset, i_wdt_timeout, i_trap_reset, i_illegal_op;
  reg         i_wake_irq, i_flags_we;
  reg [1:0]   i_bor_level;
  reg [2:0]   i_supply_below, i_osc_source_select;
  reg [4:0]   i_primary_osc_mode;
  reg [7:0]   i_osc_control_reg;
  reg [9:0]   i_flags_wdata;
  reg [23:0]  i_irq_vector, i_pc;
  wire        o_core_reset, o_clk_hold, o_cpu_freeze, o_clk_fail_trap, o_use_fast_rc;
  wire        o_pc_load;
  wire [2:0]  o_clk_source;
  wire [4:0]  o_clk_mode;
  wire [9:0]  o_reset_control_reg;
  wire [23:0] o_pc_value;
  int         err_count, cmp_count, cyc, n;
  logic [9:0] mx [3] = '{10'h187, 10'h1CF, 10'h1D7};
  // Short counts keep the run brief
  rss_reset_source_sequencer #(.POR_CYC(24'h8), .POWER_UP_TIMER_CYC(24'h10), .MON_CYC(24'h4))
    i_rss_reset_source_sequencer (
      .i_clk               (i_clk),
      .i_sys_rst           (i_sys_rst),
      .i_master_clear_n    (i_master_clear_n),
      .i_bor_level         (i_bor_level),
      .i_supply_below      (i_supply_below),
      .i_bor_enable        (i_bor_enable),
      .i_monitor_enable    (i_monitor_enable),
      .i_power_up_timer_enable       (i_power_up_timer_enable),
      .i_crystal_mode      (i_crystal_mode),
      .i_pll_used          (i_pll_used),
      .i_osc_source_select (i_osc_source_select),
      .i_primary_osc_mode  (i_primary_osc_mode),
      .i_osc_running       (i_osc_running),
      .i_osc_control_reg   (i_osc_control_reg),
      .i_sleep_mode        (i_sleep_mode),
      .i_idle_mode         (i_idle_mode),
      .i_sw_reset          (i_sw_reset),
      .i_wdt_timeout       (i_wdt_timeout),
      .i_trap_reset        (i_trap_reset),
      .i_illegal_op        (i_illegal_op),
      .i_wake_irq          (i_wake_irq),
      .i_irq_vector        (i_irq_vector),
      .i_pc                (i_pc),
      .i_flags_we          (i_flags_we),
      .i_flags_wdata       (i_flags_wdata),
      .o_core_reset        (o_core_reset),
      .o_clk_hold          (o_clk_hold),
      .o_cpu_freeze        (o_cpu_freeze),
      .o_clk_fail_trap     (o_clk_fail_trap),
      .o_use_fast_rc       (o_use_fast_rc),
      .o_clk_source        (o_clk_source),
      .o_clk_mode          (o_clk_mode),
      .o_pc_load           (o_pc_load),
      .o_pc_value          (o_pc_value),
      .o_reset_control_reg (o_reset_control_reg)
    );
  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // A hang counts as a mismatch
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test;
    end
  end
  task tick(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task chk(input string s, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task wr(input logic [9:0] d);
    i_flags_wdata = d;
    i_flags_we = 1'b1;
    tick(1);
    i_flags_we = 1'b0;
  endtask
  // Wait for reset and clock hold to clear, bounded
  task wrel(output int k);
    for (k = 0; k < 3000 && (o_core_reset | o_clk_hold) !== 1'b0; k++) tick(1);
  endtask
  task rst(input logic mon, input logic power_up_timer, input logic run);
    i_sys_rst = 1'b1;
    i_monitor_enable = mon;
    i_power_up_timer_enable = power_up_timer;
    i_osc_running = run;
    tick(8);
    i_sys_rst = 1'b0;
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {i_crystal_mode, i_sleep_mode, i_idle_mode, i_sw_reset, i_wdt_timeout} = '0;
    {i_trap_reset, i_illegal_op, i_wake_irq, i_flags_we, i_bor_level} = '0;
    {i_supply_below, i_flags_wdata} = '0;
    i_master_clear_n = 1'b1;
    i_bor_enable = 1'b1;
    i_pll_used = 1'b1;
    i_osc_control_reg = 8'h20;
    i_osc_source_select = 3'h3;
    i_primary_osc_mode = 5'h0A;
    i_irq_vector = 24'h000040;
    i_pc = 24'h000100;
    rst(1'b0, 1'b1, 1'b1);
    chk("por_flags", 10'h006, o_reset_control_reg);
    wrel(n);
    chk("por_time", 1, n >= 16);
    wr(10'h3FF);
    chk("wr", 10'h3FF, o_reset_control_reg);
    i_sw_reset = 1'b1;
    tick(1);
    i_sw_reset = 1'b0;
    chk("sw_load", 1, o_pc_load);
    chk("sw_flags", 10'h347, o_reset_control_reg);
    wr(10'h000);
    i_sleep_mode = 1'b1;
    i_wake_irq = 1'b1;
    tick(1);
    i_wake_irq = 1'b0;
    chk("irq_pc", 24'h000040, o_pc_value);
    i_wdt_timeout = 1'b1;
    tick(1);
    i_wdt_timeout = 1'b0;
    i_sleep_mode = 1'b0;
    chk("wdt_pc", 24'h000102, o_pc_value);
    chk("wdt_flags", 10'h028, o_reset_control_reg);
    // Traps after the wake, so the zero restart address is a real change
    wr(10'h000);
    i_trap_reset = 1'b1;
    tick(1);
    i_trap_reset = 1'b0;
    i_illegal_op = 1'b1;
    tick(1);
    i_illegal_op = 1'b0;
    chk("trap_flags", 10'h300, o_reset_control_reg);
    chk("trap_pc", 24'h000000, o_pc_value);
    // Pin reset awake, in sleep, in idle
    for (int m = 0; m < 3; m++) begin
      wr(10'h16F);
      i_sleep_mode = (m == 1);
      i_idle_mode = (m == 2);
      i_master_clear_n = 1'b0;
      tick(10);
      chk("master_clear_pin_flags", mx[m], o_reset_control_reg);
      i_master_clear_n = 1'b1;
      i_sleep_mode = 1'b0;
      i_idle_mode = 1'b0;
      wrel(n);
    end
    // Each brown-out level; crystal start-up on level 1, sleep on level 2
    for (int l = 0; l < 3; l++) begin
      wr(10'h004);
      i_bor_level = 2'(l);
      i_sleep_mode = (l == 2);
      i_crystal_mode = (l == 1);
      i_osc_source_select = 3'(l + 4);
      i_supply_below = 3'h7 ^ (3'h1 << l);
      tick(12);
      chk("bor_other", 0, o_core_reset);
      i_supply_below = 3'h7;
      tick(12);
      chk("bor_trip", 1, o_core_reset);
      chk("bor_flags", 10'h002, o_reset_control_reg);
      i_supply_below = 3'h0;
      i_sleep_mode = 1'b0;
      wrel(n);
      chk("bor_src", 24'(l + 4), o_clk_source);
      chk("bor_mode", 5'h0A, o_clk_mode);
      // Hold is counted from the supply drop, twelve cycles before wrel began
      if (l == 1) chk("ost", 1, n + 12 >= 1024);
    end
    // Crystal with no power-up timer: power-on 8 plus monitor delay 4
    i_crystal_mode = 1'b1;
    rst(1'b0, 1'b0, 1'b1);
    for (n = 0; n < 300 && o_core_reset !== 1'b0; n++) tick(1);
    chk("mon_delay", 1, n >= 12 && n < 16);
    i_crystal_mode = 1'b0;
    rst(1'b0, 1'b0, 1'b1);
    wrel(n);
    chk("fast_exit", 1, n < 16);
    rst(1'b0, 1'b1, 1'b0);
    tick(60);
    chk("freeze", 1, o_cpu_freeze);
    i_osc_running = 1'b1;
    tick(10);
    chk("unfreeze", 0, o_cpu_freeze);
    // Lock low keeps the clock held; raising it frees the clock
    i_osc_control_reg = 8'h00;
    rst(1'b0, 1'b0, 1'b1);
    tick(30);
    chk("pll_hold", 1, o_clk_hold);
    i_osc_control_reg = 8'h20;
    tick(2);
    chk("pll_free", 0, o_clk_hold);
    rst(1'b1, 1'b1, 1'b0);
    for (n = 0; n < 300 && o_clk_fail_trap !== 1'b1; n++) tick(1);
    chk("cf_trap", 1, o_clk_fail_trap);
    tick(1);
    chk("cf_pc", 24'h000004, o_pc_value);
    chk("cf_frc", 1, o_use_fast_rc);
    chk("cf_src", 3'h1, o_clk_source);
    chk("cf_flags", 10'h006, o_reset_control_reg);
    end_of_test;
  end
endmodule
